// ### verilog/sec_defines.svh
// constants of the serial eeprom command engine: opcodes, status layout, timing
// assumes an 8-bit address space, 16-byte pages and a 25 MHz reference clock
`ifndef SEC_DEFINES_SVH
`define SEC_DEFINES_SVH

// opcode layout: upper nibble must be zero, bit 3 is ignored
`define SEC_OP_UPPER     4'h0
`define SEC_OP_READ      3'h3
`define SEC_OP_WRITE     3'h2
`define SEC_OP_CLR_LATCH 3'h4
`define SEC_OP_SET_LATCH 3'h6
`define SEC_OP_ST_READ   3'h5
`define SEC_OP_ST_WRITE  3'h1

// status byte fields
`define SEC_ST_BUSY_BIT  0
`define SEC_ST_LATCH_BIT 1
`define SEC_ST_GUARD_LO  2
`define SEC_ST_GUARD_HI  3
`define SEC_ST_RESET     8'h00

// block guard boundaries
`define SEC_QUARTER_BASE 8'hC0
`define SEC_HALF_BASE    8'h80

// array geometry
`define SEC_PAGE_BYTES   16

// internal write cycle: longest time, rounded down
`define SEC_TWC_MS       5
`define SEC_REF_HZ       25000000
`define SEC_TWC_CYC      ((`SEC_TWC_MS * `SEC_REF_HZ) / 1000)

`endif

// ### verilog/sec_pkg.sv
// types shared by the serial eeprom command engine
// assumes sec_defines.svh carries all numeric constants
package sec_pkg;

  // decoded instruction class
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_READ,
    CMD_WRITE,
    CMD_SET,
    CMD_CLR,
    CMD_SREAD,
    CMD_SWRITE,
    CMD_BAD
  } sec_cmd_t;

  // position of the serial sequence inside one frame
  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA,
    PH_SREAD,
    PH_SWDATA,
    PH_TAIL
  } sec_phase_t;

  // what a frame left behind for the reference domain at deselect
  typedef struct packed {
    sec_cmd_t   cmd;
    logic [7:0] addr;
    logic [7:0] swdata;
    logic       closed;
    logic       swdone;
  } sec_frame_t;

endpackage : sec_pkg

// ### verilog/sec_engine.sv
// serial eeprom command engine: spi slave front end, array and status register
// assumes serial_clock comes from the host and stops outside frames,
// and that the host keeps select and pause setup/hold around clock edges
`timescale 1ns/10ps
`include "sec_defines.svh"

// What this block does
// - bytes move most significant bit first through a 7-bit instruction shifter plus the live input bit
// - serial_in captured on rising serial_clock from first edge after select
// - pause freezes the sequence at the same bit; serial_out stays off until the next falling edge
// - read 0000x011, write 0000x010, status read 0000x101, x ignored
// - latch set 0000x110, latch clear 0000x100, status write 0000x001
// - read: opcode, one address byte, then the addressed byte shifts out
// - read pointer advances after each byte and wraps FFh to 00h
// - raising select_n ends a read and stops output
// - latch sets only on deselect right after exactly eight opcode bits
// - up to 16 data bytes per write, all within one page
// - page write address wraps inside the page, overwriting earlier bytes
// - write starts only when deselect follows the last bit of a byte
// - array reads are refused during an internal write cycle
// - latch clears on reset, clear, finished writes and protect pin low
// - status: bit0 busy, bit1 latch read-only, bits 3:2 guard, 7:4 zero
// - busy reads 1 during an internal write cycle, else 0
// - latch flag mirrors the latch; set and clear work even when guarded
// - guard bits change only by status write and are not reset
// - status register readable at any time, busy or not
// - guard 00 none, 01 C0h-FFh, 10 80h-FFh, 11 all; guarded bytes refused
// - write cycle starts at deselect after valid sequence, lasts at most 5 ms
// - protect pin low refuses array and status writes and latch sets, rest works
// - serial_out changes after falling edges and floats while deselected
module sec_engine #(
  parameter int unsigned WRITE_CYCLES = `SEC_TWC_CYC
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic serial_clock,
  input  wire logic select_n,
  input  wire logic serial_in,
  input  wire logic pause_n,
  input  wire logic protect_pin_n,
  output logic      serial_out,
  output logic      serial_out_oe
);

  localparam int unsigned TW = $clog2(WRITE_CYCLES + 1);

  // refuse a zero-length write cycle
  if (WRITE_CYCLES < 1) begin : g_bad_cycles
    $error("WRITE_CYCLES must be at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // opcode decode, x bit ignored
  function automatic sec_pkg::sec_cmd_t decode(input logic [7:0] b);
    sec_pkg::sec_cmd_t c;
    c = sec_pkg::CMD_BAD;
    if (b[7:4] == `SEC_OP_UPPER) begin
      case (b[2:0])
        `SEC_OP_READ:      c = sec_pkg::CMD_READ;
        `SEC_OP_WRITE:     c = sec_pkg::CMD_WRITE;
        `SEC_OP_ST_READ:   c = sec_pkg::CMD_SREAD;
        `SEC_OP_SET_LATCH: c = sec_pkg::CMD_SET;
        `SEC_OP_CLR_LATCH: c = sec_pkg::CMD_CLR;
        `SEC_OP_ST_WRITE:  c = sec_pkg::CMD_SWRITE;
        default:           c = sec_pkg::CMD_BAD;
      endcase
    end
    return c;
  endfunction : decode

  // is this address inside the guarded block
  function automatic logic guarded(input logic [7:0] a, input logic [1:0] g);
    logic p;
    p = 1'b0;
    case (g)
      2'h0: p = 1'b0;
      2'h1: p = (a >= `SEC_QUARTER_BASE);
      2'h2: p = (a >= `SEC_HALF_BASE);
      default: p = 1'b1;
    endcase
    return p;
  endfunction : guarded

  ////////////////////////////////////////////////////////////////////////////
  // storage and reference-domain state

  logic [7:0]            mem_q [0:255];
  logic [1:0]            guard_q = 2'h0;      // nonvolatile, never reset
  logic                  latch_q;
  logic                  busy_q;
  logic [TW-1:0]         tmr_q;
  logic [1:0]            pin_s1_q;
  logic [1:0]            pin_s2_q;
  logic [1:0]            pin_s3_q;
  logic [1:0]            pin_f_q;
  logic [1:0]            pin_f_d;
  logic [7:0]            status_w;

  ////////////////////////////////////////////////////////////////////////////
  // link-domain state

  sec_pkg::sec_phase_t   phase_q;
  logic [2:0]            bit_cnt_q;
  logic [6:0]            shift_q;
  sec_pkg::sec_frame_t   rec_q = '0;
  logic [7:0]            pbuf_q [0:`SEC_PAGE_BYTES-1];
  logic [`SEC_PAGE_BYTES-1:0] pmask_q = '0;
  logic [7:0]            ptr_q;
  logic [7:0]            tx_q;
  logic [7:0]            st1_q;
  logic [7:0]            st2_q;
  logic [7:0]            st3_q;
  logic [7:0]            lstat_q;
  logic [7:0]            in_byte;
  logic                  byte_end;
  logic                  so_off;

  assign in_byte  = {shift_q, serial_in};
  assign byte_end = (bit_cnt_q == 3'h7);
  assign so_off   = select_n | ~pause_n;

  // status byte as software sees it
  assign status_w = {4'h0, guard_q, latch_q, busy_q};

  ////////////////////////////////////////////////////////////////////////////
  // link: bit counter and phase, cleared by deselect

  // pause_n is used directly: it may only move while serial_clock is low,
  // so it is stable at every rising edge; a synchroniser would swallow edges
  always_ff @(posedge serial_clock or posedge select_n) begin
    if (select_n) begin
      bit_cnt_q <= 3'h0;
      phase_q   <= sec_pkg::PH_CMD;
      shift_q   <= 7'h00;
    end else if (pause_n) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      shift_q   <= {shift_q[5:0], serial_in};
      if (byte_end) begin
        unique case (phase_q)
          sec_pkg::PH_CMD: begin
            unique case (decode(in_byte))
              sec_pkg::CMD_READ:
                phase_q <= lstat_q[`SEC_ST_BUSY_BIT] ? sec_pkg::PH_TAIL
                                                     : sec_pkg::PH_ADDR;
              sec_pkg::CMD_WRITE:  phase_q <= sec_pkg::PH_ADDR;
              sec_pkg::CMD_SREAD:  phase_q <= sec_pkg::PH_SREAD;
              sec_pkg::CMD_SWRITE: phase_q <= sec_pkg::PH_SWDATA;
              default:             phase_q <= sec_pkg::PH_TAIL;
            endcase
          end
          sec_pkg::PH_ADDR:
            phase_q <= (rec_q.cmd == sec_pkg::CMD_READ) ? sec_pkg::PH_RDATA
                                                        : sec_pkg::PH_WDATA;
          sec_pkg::PH_SWDATA: phase_q <= sec_pkg::PH_TAIL;
          default:            phase_q <= phase_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link: frame record, page buffer, pointer and transmit byte

  // not cleared by deselect: the reference domain reads these after the
  // frame ends, while serial_clock is still and they cannot move
  always_ff @(posedge serial_clock) begin
    if (!select_n && pause_n) begin
      rec_q.closed <= byte_end;
      if (phase_q == sec_pkg::PH_CMD && bit_cnt_q == 3'h0) begin
        rec_q.cmd <= sec_pkg::CMD_NONE;
      end
      // any bit past the expected length spoils a latch or status command
      if (phase_q == sec_pkg::PH_TAIL) begin
        rec_q.cmd <= sec_pkg::CMD_NONE;
      end
      if (byte_end) begin
        unique case (phase_q)
          sec_pkg::PH_CMD: begin
            rec_q.cmd    <= decode(in_byte);
            rec_q.swdone <= 1'b0;
            pmask_q      <= '0;
            tx_q         <= lstat_q;
          end
          sec_pkg::PH_ADDR: begin
            rec_q.addr <= in_byte;
            ptr_q      <= in_byte + 8'h01;
            tx_q       <= mem_q[in_byte];
            if (rec_q.cmd == sec_pkg::CMD_WRITE) begin
              ptr_q <= in_byte;
            end
          end
          sec_pkg::PH_WDATA: begin
            pbuf_q[ptr_q[3:0]]  <= in_byte;
            pmask_q[ptr_q[3:0]] <= 1'b1;
            ptr_q <= {ptr_q[7:4], ptr_q[3:0] + 4'h1};
          end
          sec_pkg::PH_RDATA: begin
            // array is stable here: no write cycle starts inside a frame
            tx_q  <= mem_q[ptr_q];
            ptr_q <= ptr_q + 8'h01;
          end
          sec_pkg::PH_SREAD: tx_q <= lstat_q;
          sec_pkg::PH_SWDATA: begin
            rec_q.swdata <= in_byte;
            rec_q.swdone <= 1'b1;
          end
          default: tx_q <= tx_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link: status word brought over from the reference domain

  // three flops; a bit is taken only once stages two and three agree.
  // the eight opcode edges flush the chain before the value is used
  always_ff @(posedge serial_clock) begin
    st1_q   <= status_w;
    st2_q   <= st1_q;
    st3_q   <= st2_q;
    lstat_q <= (st3_q & ~(st2_q ^ st3_q)) | (lstat_q & (st2_q ^ st3_q));
  end

  ////////////////////////////////////////////////////////////////////////////
  // link: serial output on falling edges

  // floats at once on deselect or pause; bit index follows the counter
  always_ff @(negedge serial_clock or posedge so_off) begin
    if (so_off) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      // parked low outside read phases: tx_q is unknown before the first load
      serial_out    <= tx_q[~bit_cnt_q] &
                       ((phase_q == sec_pkg::PH_RDATA) || (phase_q == sec_pkg::PH_SREAD));
      serial_out_oe <= (phase_q == sec_pkg::PH_RDATA) ||
                       (phase_q == sec_pkg::PH_SREAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference: pin synchronisers for select and protect

  // bit 0 select_n, bit 1 protect_pin_n
  assign pin_f_d = (pin_s3_q & ~(pin_s2_q ^ pin_s3_q)) |
                   (pin_f_q & (pin_s2_q ^ pin_s3_q));

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_s1_q <= 2'h3;
      pin_s2_q <= 2'h3;
      pin_s3_q <= 2'h3;
      pin_f_q  <= 2'h3;
    end else begin
      pin_s1_q <= {protect_pin_n, select_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= pin_f_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference: end-of-frame decisions

  logic sel_rise;
  logic prot_ok;
  logic aw_ok;
  logic sw_ok;
  logic set_ok;
  logic clr_ok;
  logic done;

  assign sel_rise = pin_f_d[0] & ~pin_f_q[0];
  assign prot_ok  = pin_f_q[1];
  assign aw_ok    = sel_rise && rec_q.cmd == sec_pkg::CMD_WRITE && rec_q.closed &&
                    (pmask_q != '0) && latch_q && prot_ok && !busy_q;
  assign sw_ok    = sel_rise && rec_q.cmd == sec_pkg::CMD_SWRITE && rec_q.closed &&
                    rec_q.swdone && latch_q && prot_ok && !busy_q;
  assign set_ok   = sel_rise && rec_q.cmd == sec_pkg::CMD_SET && rec_q.closed;
  assign clr_ok   = sel_rise && rec_q.cmd == sec_pkg::CMD_CLR && rec_q.closed;
  assign done     = busy_q && (tmr_q == '0);

  ////////////////////////////////////////////////////////////////////////////
  // reference: write cycle timer

  // busy for exactly WRITE_CYCLES reference cycles
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      tmr_q  <= '0;
    end else if (aw_ok || sw_ok) begin
      busy_q <= 1'b1;
      tmr_q  <= TW'(WRITE_CYCLES - 1);
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      tmr_q  <= tmr_q - TW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference: write enable latch

  // protect pin wins over everything; a set does not survive it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      latch_q <= 1'b0;
    end else if (!prot_ok || clr_ok || done) begin
      latch_q <= 1'b0;
    end else if (set_ok) begin
      latch_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference: guard bits and array commit

  // guard bits have no reset: they model nonvolatile cells
  always_ff @(posedge ref_clk) begin
    if (sw_ok) begin
      guard_q <= rec_q.swdata[`SEC_ST_GUARD_HI:`SEC_ST_GUARD_LO];
    end
  end

  // whole page lands at commit; reads stay refused until busy drops,
  // so nobody can see the array before the cycle would have ended
  always_ff @(posedge ref_clk) begin
    if (aw_ok) begin
      for (int i = 0; i < `SEC_PAGE_BYTES; i++) begin
        if (pmask_q[i] && !guarded({rec_q.addr[7:4], 4'(i)}, guard_q)) begin
          mem_q[{rec_q.addr[7:4], 4'(i)}] <= pbuf_q[i];
        end
      end
    end
  end

endmodule : sec_engine

// ### test/sec_engine_asserts.sv
// port checker of the serial eeprom command engine
// assumes bind to sec_engine; link logic is cleared by select_n high
`timescale 1ns/10ps
module sec_engine_asserts #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic serial_clock,
  input wire logic select_n,
  input wire logic serial_in,
  input wire logic pause_n,
  input wire logic protect_pin_n,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [7:0] edge_cnt_q;
  logic [7:0] op_q;
  logic       so_rise_q;
  logic       op_rd;
  logic       op_st;

  ////////////////////////////////////////
  // frame position and opcode, rebuilt from the pins
  always_ff @(posedge serial_clock or posedge select_n) begin
    if (select_n) begin
      edge_cnt_q <= 8'h00;
      op_q       <= 8'h00;
    end else if (pause_n) begin
      if (edge_cnt_q != 8'hFF) edge_cnt_q <= edge_cnt_q + 8'h01;
      if (edge_cnt_q < 8'h08) op_q <= {op_q[6:0], serial_in};
    end
  end
  // output level seen by the host at each rising edge
  always_ff @(posedge serial_clock) begin
    so_rise_q <= serial_out;
  end
  assign op_rd = (op_q[7:4] == 4'h0) && (op_q[2:0] == 3'h3);
  assign op_st = (op_q[7:4] == 4'h0) && (op_q[2:0] == 3'h5);

  ////////////////////////////////////////
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    select_n |-> !serial_out_oe && !serial_out) else $error("output active while deselected");
  a_pause_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !select_n && !pause_n |-> !serial_out_oe) else $error("output driven during pause");
  a_out_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !serial_out_oe |-> !serial_out) else $error("output not parked while disabled");
  a_out_on_fall: assert property (@(negedge serial_clock) disable iff (select_n)
    serial_out_oe |-> serial_out == so_rise_q) else $error("output moved outside falling edge");
  a_read_late: assert property (@(negedge serial_clock) disable iff (select_n)
    serial_out_oe && op_rd |-> edge_cnt_q > 8'd16) else $error("array data before address done");
  a_status_late: assert property (@(negedge serial_clock) disable iff (select_n)
    serial_out_oe && op_st |-> edge_cnt_q > 8'd8) else $error("status data before opcode done");
  a_oe_only_reads: assert property (@(negedge serial_clock) disable iff (select_n)
    serial_out_oe |-> op_rd || op_st) else $error("output driven for a non-read opcode");
  a_status_starts: assert property (@(negedge serial_clock) disable iff (select_n)
    op_st && edge_cnt_q == 8'd9 && pause_n |-> serial_out_oe) else $error("status read not served");
  a_status_upper: assert property (@(negedge serial_clock) disable iff (select_n)
    op_st && serial_out_oe && edge_cnt_q inside {[8'd9:8'd12]} |-> !serial_out)
    else $error("status upper bits not zero");

  c_status: cover property (@(negedge serial_clock) op_st && serial_out_oe);
  c_read: cover property (@(negedge serial_clock) op_rd && serial_out_oe && edge_cnt_q > 8'd24);
  c_pause: cover property (@(posedge ref_clk) !select_n && !pause_n);
endmodule : sec_engine_asserts

bind sec_engine sec_engine_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .serial_clock(serial_clock), .select_n(select_n),
  .serial_in(serial_in), .pause_n(pause_n), .protect_pin_n(protect_pin_n),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe));

// ### test/sec_host_model.sv
// spi host master model, mode 0, msb first
// assumes the bench calls its tasks; link clock runs only inside frames
`timescale 1ns/10ps
module sec_host_model (
  output logic      serial_clock,
  output logic      select_n,
  output logic      serial_in,
  output logic      pause_n,
  input  wire logic serial_out,
  input  wire logic serial_out_oe
);
  logic [7:0] rx_byte;
  event       rx_ev;

  ////////////////////////////////////////
  // idle bus at time zero
  initial begin
    serial_clock = 1'b0;
    select_n     = 1'b1;
    serial_in    = 1'b0;
    pause_n      = 1'b1;
  end
  // odd offset keeps the link out of step with the reference clock
  task automatic fo();
    #13 select_n <= 1'b0;
    #32;
  endtask : fo
  // nb bits of tx, pausing before bit pz; ck reports the byte read back
  task automatic sb(input logic [7:0] tx, input int nb, input int pz, input bit ck);
    for (int i = 7; i > 7 - nb; i--) begin
      if (i == pz) begin
        pause_n   <= 1'b0;
        serial_in <= ~serial_in;
        #96 pause_n <= 1'b1;
        #32;
      end
      serial_in <= tx[i];
      #32 serial_clock <= 1'b1;
      rx_byte[i] = serial_out_oe ? serial_out : 1'b1; // undriven line reads as pulled up
      #32 serial_clock <= 1'b0;
    end
    if (ck) ->rx_ev;
  endtask : sb
  // released data line shows the inverse; gap covers the commit
  task automatic fc();
    #32 select_n <= 1'b1;
    serial_in <= ~serial_in;
    #256;
  endtask : fc
endmodule : sec_host_model

// ### test/sec_engine_tb.sv
// self-checking bench of the serial eeprom command engine
// assumes the host model owns the link and reports read bytes by event
`timescale 1ns/10ps
module sec_engine_tb;
  logic       ref_clk;
  logic       reset_n;
  logic       protect_pin_n;
  logic       serial_clock;
  logic       select_n;
  logic       serial_in;
  logic       pause_n;
  logic       serial_out;
  logic       serial_out_oe;
  logic [7:0] mem [256];
  logic [7:0] exp_q [$];
  logic [7:0] ga [3] = '{8'h7F, 8'hBF, 8'hFF};
  logic [1:0] gd;
  int         err_count;
  int         n_compared;
  int         seed;

  sec_engine #(.WRITE_CYCLES(200)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .serial_clock(serial_clock), .select_n(select_n),
    .serial_in(serial_in), .pause_n(pause_n), .protect_pin_n(protect_pin_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  sec_host_model u_host (
    .serial_clock(serial_clock), .select_n(select_n), .serial_in(serial_in),
    .pause_n(pause_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  ////////////////////////////////////////
  // 25 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  // oldest note against each reported byte
  initial begin
    forever begin
      @(u_host.rx_ev);
      chk(u_host.rx_byte, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
    end
  end
  // a hang counts as a mismatch
  initial begin
    repeat (50000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end

  ////////////////////////////////////////
  function automatic bit prot(input logic [7:0] p);
    return !protect_pin_n || gd == 2'd3 || (gd == 2'd2 && p[7]) || (gd == 2'd1 && p[7:6] == 2'b11);
  endfunction : prot
  task automatic sb(input logic [7:0] v, input bit ck);
    u_host.sb(v, 8, 9, ck);
  endtask : sb
  task automatic cmd(input logic [7:0] op);
    u_host.fo();
    sb(op, 1'b0);
    u_host.fc();
  endtask : cmd
  task automatic rs(input logic [7:0] e);
    exp_q.push_back(e);
    u_host.fo();
    sb(8'h05, 1'b0);
    sb(8'h00, 1'b1);
    u_host.fc();
  endtask : rs
  // bounded busy poll; the frames themselves are not compared
  task automatic poll();
    for (int k = 0; k < 60; k++) begin
      u_host.fo();
      sb(8'h05, 1'b0);
      sb(8'h00, 1'b0);
      u_host.fc();
      if (u_host.rx_byte[0] === 1'b0) return;
    end
    err_count++;
    complete_run();
  endtask : poll
  task automatic wr(input logic [7:0] a, input int n, input bit bz);
    logic [7:0] d;
    logic [7:0] p;
    cmd(8'h06);
    u_host.fo();
    sb(8'h0A, 1'b0);
    sb(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      p = {a[7:4], a[3:0] + 4'(i)};
      u_host.sb(d, 8, (i == 1) ? 4 : 9, 1'b0);
      if (!prot(p)) mem[p] = d;
    end
    u_host.fc();
    if (bz) begin
      rs(8'h03);
      exp_q.push_back(8'hFF);
      u_host.fo();
      sb(8'h03, 1'b0);
      sb(a, 1'b0);
      sb(8'h00, 1'b1);
      u_host.fc();
    end
    poll();
  endtask : wr
  task automatic rd(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) exp_q.push_back(mem[8'(a + i)]);
    u_host.fo();
    sb(8'h0B, 1'b0);
    u_host.sb(a, 8, 3, 1'b0);
    for (int i = 0; i < n; i++) sb(8'h00, 1'b1);
    u_host.fc();
  endtask : rd
  task automatic sw(input logic [7:0] v);
    cmd(8'h06);
    u_host.fo();
    sb(8'h09, 1'b0);
    sb(v, 1'b0);
    u_host.fc();
    poll();
    if (protect_pin_n) gd = v[3:2];
  endtask : sw
  task automatic pin(input logic v);
    @(posedge ref_clk);
    protect_pin_n <= v;
    repeat (4) @(posedge ref_clk);
  endtask : pin

  ////////////////////////////////////////
  // main sequence
  initial begin
    reset_n = 1'b0;
    protect_pin_n = 1'b1;
    seed = 98;
    gd = 2'd0;
    repeat (8) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rs(8'h00);
    cmd(8'h0E);
    rs(8'h02);
    cmd(8'h0C);
    rs(8'h00);
    u_host.fo();
    sb(8'h06, 1'b0);
    u_host.sb(8'h00, 1, 9, 1'b0);
    u_host.fc();
    rs(8'h00);
    u_host.fo();
    sb(8'h02, 1'b0);
    sb(8'h30, 1'b0);
    sb(8'h5A, 1'b0);
    u_host.fc();
    rs(8'h00);
    $display("latch tests done");
    wr(8'h3E, 18, 1'b1);
    rs(8'h00);
    rd(8'h3C, 4);
    wr(8'hFF, 1, 1'b0);
    wr(8'h00, 1, 1'b0);
    rd(8'hFF, 2);
    $display("array tests done");
    for (int g = 0; g < 4; g++) begin
      sw({4'h0, 2'(g), 2'b00});
      rs({4'h0, 2'(g), 2'b00});
      foreach (ga[i]) wr(ga[i], 1, 1'b0);
      foreach (ga[i]) rd(ga[i], 1);
    end
    $display("guard tests done");
    pin(1'b0);
    cmd(8'h06);
    rs(8'h0C);
    sw(8'h00);
    rs(8'h0C);
    pin(1'b1);
    sw(8'h00);
    rs(8'h00);
    cmd(8'h06);
    u_host.fo();
    sb(8'h02, 1'b0);
    sb(8'h3C, 1'b0);
    sb(8'hA5, 1'b0);
    u_host.sb(8'h0F, 4, 9, 1'b0);
    u_host.fc();
    poll();
    rs(8'h02);
    rd(8'h3C, 1);
    cmd(8'h04);
    $display("protect and abort tests done");
    chk(8'(exp_q.size()), 8'h00);
    complete_run();
  end
endmodule : sec_engine_tb
